// [rtl/mbs_barrier_seq.v]
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "mbs_consts.vh"
module mbs_barrier_seq
(
  input wire ref_clk,
  input wire rst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire txn_issue,
  input wire probe_cmd_valid,
  input wire probe_commit_flag,
  input wire system_data_control_cmd_cmd_valid,
  input wire system_data_control_cmd_commit_flag,
  input wire barrier_done_response,
  output reg barrier_cmd_valid,
  output reg barrier_ack,
  input wire full_barrier_fetch,
  input wire issue_queue_empty,
  input wire maf_pending,
  input wire maf_dstream_refs,
  input wire store_queue_empty,
  input wire load_queue_empty,
  input wire write_barrier_ready,
  input wire marked_probe_resp_sent,
  input wire probe_queue_empty,
  input wire dtlb_move_queued,
  input wire dtlb_move_issued,
  input wire itlb_move_queued,
  input wire itlb_move_issued,
  input wire pte_load_done,
  output wire map_stall,
  output wire maf_stall,
  output reg maf_flush,
  output reg mark_youngest_probe,
  output reg writeable_ptr_stall,
  output reg merge_close,
  output reg barrier_complete,
  output reg scoreboard_bit0,
  output reg scoreboard_bit4,
  output reg fetch_stall,
  output reg prefetch_restart,
  input wire io_write_buffer_push_valid,
  output wire io_write_buffer_push_ready,
  input wire [`MBS_ADDR_W-1:0] io_write_buffer_push_addr,
  input wire [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] io_write_buffer_push_data,
  output wire io_write_buffer_drain_valid,
  input wire io_write_buffer_drain_ready,
  output wire [`MBS_ADDR_W-1:0] io_write_buffer_drain_addr,
  output wire [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] io_write_buffer_drain_data
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_WAIT_IQ = 4'h1;
  localparam [3:0] ST_FLUSH = 4'h2;
  localparam [3:0] ST_SEND_CMD = 4'h3;
  localparam [3:0] ST_WAIT_ACK = 4'h4;
  localparam [3:0] ST_WAIT_ZERO = 4'h5;
  localparam [3:0] ST_WAIT_DRAIN = 4'h6;
  localparam [3:0] ST_WAIT_PROBE = 4'h7;

  reg [31:0] ctrl;
  reg [3:0] uncommitted_txn_count;
  reg [3:0] state;
  reg is_write_barrier;
  reg is_full_barrier;
  reg is_itlb;
  reg pend_full;
  reg pend_wb;
  reg pend_dtlb;
  reg pend_itlb;
  reg [3:0] next_count;
  reg [3:0] next_state;
  reg step_to_zero;
  wire barrier_bus_cmd_enable;
  wire tlb_fill_barrier_enable;
  wire saturated;
  wire [2:0] io_write_buffer_count;
  wire io_write_buffer_empty;
  wire [1:0] commit_events;
  wire apb_wr;
  wire hit_ctrl;
  wire hit_status;
  wire queues_empty;
  wire start_any;

  assign barrier_bus_cmd_enable = ctrl[`MBS_CTRL_BUS_EN];
  assign tlb_fill_barrier_enable = ctrl[`MBS_CTRL_TLB_EN];

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign hit_ctrl = (paddr == `MBS_OFF_CTRL);
  assign hit_status = (paddr == `MBS_OFF_STATUS);
  assign pslverr = psel && penable && !hit_ctrl && !hit_status;
  assign apb_wr = psel && penable && pwrite;

  always @(posedge ref_clk)
  begin
    if (rst)
      ctrl <= `MBS_CTRL_RESET;
    else if (apb_wr && hit_ctrl)
      ctrl <= {30'h0, pwdata[1:0]};
  end

  always @*
  begin
    prdata = 32'h0000_0000;
    if (hit_ctrl)
      prdata = ctrl;
    else if (hit_status)
    begin
      prdata[`MBS_ST_CNT_LSB+3:`MBS_ST_CNT_LSB] = uncommitted_txn_count;
      prdata[`MBS_ST_STATE_LSB+3:`MBS_ST_STATE_LSB] = state;
      prdata[`MBS_ST_IO_WRITE_BUFFER_LSB+2:`MBS_ST_IO_WRITE_BUFFER_LSB] = io_write_buffer_count;
      prdata[`MBS_ST_SATURATED] = saturated;
      prdata[`MBS_ST_SB0] = scoreboard_bit0;
      prdata[`MBS_ST_SB4] = scoreboard_bit4;
      prdata[`MBS_ST_FETCH_STALL] = fetch_stall;
    end
  end

  // probe commits are always counted, saturated or not
  assign commit_events = {1'b0, probe_cmd_valid && probe_commit_flag}
    + {1'b0, system_data_control_cmd_cmd_valid && system_data_control_cmd_commit_flag};

  always @*
  begin
    next_count = uncommitted_txn_count;
    if (txn_issue && !barrier_bus_cmd_enable && uncommitted_txn_count != `MBS_CNT_MAX)
      next_count = next_count + 4'h1;
    if (next_count >= {2'h0, commit_events})
      next_count = next_count - {2'h0, commit_events};
    else
      next_count = 4'h0;
    step_to_zero = (uncommitted_txn_count == 4'h1) && (next_count == 4'h0);
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      uncommitted_txn_count <= 4'h0;
    else
      uncommitted_txn_count <= next_count;
  end

  assign saturated = (uncommitted_txn_count == `MBS_CNT_MAX);
  // write barrier keeps the miss file and write buffer still until satisfied
  assign maf_stall = saturated || (is_write_barrier && state != ST_IDLE);
  assign map_stall = is_full_barrier && state != ST_IDLE;
  assign queues_empty = !maf_dstream_refs && store_queue_empty && load_queue_empty && io_write_buffer_empty;
  assign start_any = (state == ST_IDLE) && (pend_dtlb || pend_itlb || pend_full || pend_wb);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (pend_dtlb || pend_itlb)
          next_state = ST_FLUSH;
        else if (pend_full)
          next_state = ST_WAIT_IQ;
        else if (pend_wb)
          next_state = barrier_bus_cmd_enable ? ST_SEND_CMD : ST_WAIT_ZERO;
      ST_WAIT_IQ:
        if (issue_queue_empty)
          next_state = ST_FLUSH;
      ST_FLUSH:
        if (!maf_pending && io_write_buffer_empty)
          next_state = barrier_bus_cmd_enable ? ST_SEND_CMD : ST_WAIT_ZERO;
      ST_SEND_CMD:
        next_state = ST_WAIT_ACK;
      ST_WAIT_ACK:
        if (barrier_done_response)
          next_state = is_write_barrier ? ST_WAIT_PROBE : ST_WAIT_DRAIN;
      ST_WAIT_ZERO:
        if (step_to_zero || uncommitted_txn_count == 4'h0)
          next_state = is_write_barrier ? ST_WAIT_PROBE : ST_WAIT_DRAIN;
      ST_WAIT_DRAIN:
        if (queues_empty)
          next_state = ST_WAIT_PROBE;
      ST_WAIT_PROBE:
        if (marked_probe_resp_sent)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      is_write_barrier <= 1'b0;
      is_full_barrier <= 1'b0;
      is_itlb <= 1'b0;
      pend_full <= 1'b0;
      pend_wb <= 1'b0;
      pend_dtlb <= 1'b0;
      pend_itlb <= 1'b0;
      barrier_cmd_valid <= 1'b0;
      barrier_ack <= 1'b0;
      mark_youngest_probe <= 1'b0;
      maf_flush <= 1'b0;
      writeable_ptr_stall <= 1'b0;
      merge_close <= 1'b0;
      barrier_complete <= 1'b0;
      prefetch_restart <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // a new request in the start cycle stays pending: set wins
      pend_full <= (pend_full && !(start_any && !pend_dtlb && !pend_itlb))
        || full_barrier_fetch;
      pend_wb <= (pend_wb && !(start_any && !pend_dtlb && !pend_itlb && !pend_full))
        || write_barrier_ready;
      pend_dtlb <= (pend_dtlb && !start_any)
        || (dtlb_move_issued && tlb_fill_barrier_enable);
      pend_itlb <= (pend_itlb && !(start_any && !pend_dtlb))
        || (itlb_move_issued && tlb_fill_barrier_enable);
      if (start_any)
      begin
        is_write_barrier <= !pend_dtlb && !pend_itlb && !pend_full;
        is_full_barrier <= !pend_dtlb && !pend_itlb && pend_full;
        is_itlb <= !pend_dtlb && pend_itlb;
      end
      else if (state != ST_IDLE && next_state == ST_IDLE)
      begin
        is_write_barrier <= 1'b0;
        is_full_barrier <= 1'b0;
        is_itlb <= 1'b0;
      end
      barrier_cmd_valid <= (next_state == ST_SEND_CMD);
      barrier_ack <= (state == ST_WAIT_ACK) && barrier_done_response && is_write_barrier;
      mark_youngest_probe <= ((state == ST_WAIT_ACK) && barrier_done_response)
        || ((state == ST_WAIT_ZERO) && (next_state != ST_WAIT_ZERO));
      maf_flush <= (next_state == ST_FLUSH);
      // writeable pointer held until the write barrier is satisfied
      if (start_any && !pend_dtlb && !pend_itlb && !pend_full)
        writeable_ptr_stall <= 1'b1;
      else if (state == ST_WAIT_PROBE && marked_probe_resp_sent)
        writeable_ptr_stall <= 1'b0;
      merge_close <= start_any && !pend_dtlb && !pend_itlb;
      barrier_complete <= (state == ST_WAIT_PROBE) && marked_probe_resp_sent;
      prefetch_restart <= (state == ST_WAIT_PROBE) && marked_probe_resp_sent && is_itlb;
    end
  end

  // scoreboard bits; bit 4 is released once the move issues
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      scoreboard_bit0 <= 1'b0;
      scoreboard_bit4 <= 1'b0;
      fetch_stall <= 1'b0;
    end
    else
    begin
      if (dtlb_move_queued || itlb_move_queued)
        scoreboard_bit4 <= 1'b1;
      else if (dtlb_move_issued || itlb_move_issued)
        scoreboard_bit4 <= 1'b0;
      if (dtlb_move_queued || itlb_move_queued)
        scoreboard_bit0 <= 1'b1;
      else if ((dtlb_move_issued || itlb_move_issued) && !tlb_fill_barrier_enable)
        scoreboard_bit0 <= 1'b0;
      else if (state == ST_WAIT_PROBE && marked_probe_resp_sent && !is_write_barrier
        && !is_full_barrier)
        scoreboard_bit0 <= 1'b0;
      if (pte_load_done && tlb_fill_barrier_enable)
        fetch_stall <= 1'b1;
      else if (probe_queue_empty)
        fetch_stall <= 1'b0;
    end
  end

  mbs_io_write_buffer u_io_write_buffer
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .push_valid(io_write_buffer_push_valid),
    .push_ready(io_write_buffer_push_ready),
    .push_addr(io_write_buffer_push_addr),
    .push_data(io_write_buffer_push_data),
    .merge_close(merge_close || maf_flush),
    .hold(maf_stall),
    .drain_valid(io_write_buffer_drain_valid),
    .drain_ready(io_write_buffer_drain_ready),
    .drain_addr(io_write_buffer_drain_addr),
    .drain_data(io_write_buffer_drain_data),
    .entry_count(io_write_buffer_count),
    .empty(io_write_buffer_empty)
  );
endmodule

// [shared/mbs_consts.vh]
// Overview of operation
// - io write buffer holds four 64-byte entries with address and control.
// - barrier_bus_cmd_enable picks bus barrier command or internal commit tracking.
// - with enable clear, each counted system command bumps uncommitted_txn_count.
// - a probe or data-control command with commit_flag decrements the count.
// - count at 15 stops miss address file and io write buffer processing.
// - probes keep being handled whatever the count, even saturated.
// - full barrier stalls in map stage, holding younger instructions until done.
// - bus disabled: after issue queue empties, flush, mark probe on one-to-zero step.
// - full barrier ends with queues empty and marked probe response sent.
// - bus enabled: flush, send barrier command, await acknowledge, mark youngest probe.
// - write barrier waits ready, then stalls writeable pointer, notifies, closes merge.
// - write barrier, bus disabled: stall, mark on one-to-zero, done on probe response.
// - write barrier, bus enabled: command, done response, acknowledge, mark, probe response.
// - queuing the data tlb entry move sets scoreboard bits 4 and 0.
// - issuing that move starts barrier; bit 0 stays set until barrier completes.
// - instruction tlb fill stalls fetch until probe queue drains; restart prefetch after.
// - clearing tlb_fill_barrier_enable skips barriers in tlb fills, uniprocessor only.
`ifndef MBS_CONSTS_VH
`define MBS_CONSTS_VH
`define MBS_OFF_CTRL 12'h000
`define MBS_OFF_STATUS 12'h004
`define MBS_CTRL_BUS_EN 0
`define MBS_CTRL_TLB_EN 1
`define MBS_CTRL_RESET 32'h0000_0002
`define MBS_ST_CNT_LSB 0
`define MBS_ST_STATE_LSB 4
`define MBS_ST_IO_WRITE_BUFFER_LSB 8
`define MBS_ST_SATURATED 11
`define MBS_ST_SB0 12
`define MBS_ST_SB4 13
`define MBS_ST_FETCH_STALL 14
`define MBS_CNT_MAX 4'hF
`define MBS_IO_WRITE_BUFFER_ENTRIES 4
`define MBS_IO_WRITE_BUFFER_DATA_W 512
`define MBS_ADDR_W 40
`endif

// [rtl/mbs_io_write_buffer.v]
`timescale 1ns/1ps
`include "mbs_consts.vh"
module mbs_io_write_buffer
(
  input wire ref_clk,
  input wire rst,
  input wire push_valid,
  output wire push_ready,
  input wire [`MBS_ADDR_W-1:0] push_addr,
  input wire [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] push_data,
  input wire merge_close,
  input wire hold,
  output wire drain_valid,
  input wire drain_ready,
  output reg [`MBS_ADDR_W-1:0] drain_addr,
  output reg [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] drain_data,
  output reg [2:0] entry_count,
  output wire empty
);
  reg [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] data_mem [0:`MBS_IO_WRITE_BUFFER_ENTRIES-1];
  reg [`MBS_ADDR_W-1:0] addr_mem [0:`MBS_IO_WRITE_BUFFER_ENTRIES-1];
  reg [1:0] wr_ptr;
  reg [1:0] rd_ptr;
  reg merge_closed;
  wire do_push;
  wire do_pop;
  wire head_ready;
  wire [1:0] next_rd_ptr;

  assign push_ready = (entry_count != 3'h4);
  assign do_push = push_valid && push_ready;
  // newest entry stays open for merging until closed or followed
  assign head_ready = (entry_count > 3'h1) || ((entry_count == 3'h1) && merge_closed);
  assign drain_valid = head_ready && !hold;
  assign do_pop = drain_valid && drain_ready;
  assign empty = (entry_count == 3'h0);
  assign next_rd_ptr = do_pop ? rd_ptr + 2'h1 : rd_ptr;

  always @(posedge ref_clk)
  begin
    if (do_push)
    begin
      data_mem[wr_ptr] <= push_data;
      addr_mem[wr_ptr] <= push_addr;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      entry_count <= 3'h0;
      merge_closed <= 1'b0;
      drain_addr <= {`MBS_ADDR_W{1'b0}};
      drain_data <= {`MBS_IO_WRITE_BUFFER_DATA_W{1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 2'h1;
      rd_ptr <= next_rd_ptr;
      entry_count <= entry_count + {2'h0, do_push} - {2'h0, do_pop};
      // close wins over a simultaneous push reopening
      if (merge_close)
        merge_closed <= 1'b1;
      else if (do_push)
        merge_closed <= 1'b0;
      // data for the head is registered one cycle ahead of its use
      drain_addr <= addr_mem[next_rd_ptr];
      drain_data <= data_mem[next_rd_ptr];
    end
  end
endmodule

// [verif/mbs_chk.sv]
`timescale 1ns/1ps
module mbs_chk
(
  input wire ref_clk,
  input wire rst,
  input wire barrier_cmd_valid,
  input wire barrier_ack,
  input wire barrier_done_response,
  input wire mark_youngest_probe,
  input wire barrier_complete,
  input wire marked_probe_resp_sent,
  input wire dtlb_move_queued,
  input wire dtlb_move_issued,
  input wire itlb_move_issued,
  input wire scoreboard_bit0,
  input wire scoreboard_bit4,
  input wire writeable_ptr_stall,
  input wire merge_close,
  input wire maf_stall,
  input wire maf_flush,
  input wire map_stall,
  input wire fetch_stall,
  input wire probe_queue_empty
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  AST_CMD_PULSE: assert property (barrier_cmd_valid |=> !barrier_cmd_valid)
    else $error("barrier command held too long");
  AST_CMD_FLUSH: assert property (barrier_cmd_valid && map_stall |-> $past(maf_flush))
    else $error("barrier command before flush");
  AST_ACK_MARK: assert property (barrier_ack
    |-> mark_youngest_probe && $past(barrier_done_response)) else $error("ack without done");
  AST_MARK_PULSE: assert property (mark_youngest_probe |=> !mark_youngest_probe)
    else $error("mark longer than one cycle");
  AST_COMPLETE: assert property (barrier_complete |-> $past(marked_probe_resp_sent))
    else $error("completion without probe response");
  AST_MAP_RELEASE: assert property ($fell(map_stall) |-> barrier_complete)
    else $error("map stall dropped early");
  AST_SB_SET: assert property (dtlb_move_queued && !dtlb_move_issued
    |=> scoreboard_bit4 && scoreboard_bit0) else $error("scoreboard bits not set");
  AST_SB0_CLEAR: assert property ($fell(scoreboard_bit0) |-> barrier_complete
    || $past(barrier_complete) || $past(dtlb_move_issued) || $past(itlb_move_issued))
    else $error("scoreboard bit 0 cleared early");
  AST_WPTR_MERGE: assert property ($rose(writeable_ptr_stall) |-> merge_close && maf_stall)
    else $error("merge not closed at write barrier");
  AST_WB_MAF: assert property (writeable_ptr_stall |-> maf_stall)
    else $error("miss file runs during write barrier");
  AST_FETCH_RELEASE: assert property ($fell(fetch_stall) |-> $past(probe_queue_empty))
    else $error("fetch released with probes pending");
  cover property (barrier_ack);
  cover property (barrier_complete && $past(map_stall));
  cover property ($fell(fetch_stall));
endmodule
bind mbs_barrier_seq mbs_chk u_mbs_chk (.*);

// [verif/mbs_sys_model.sv]
`timescale 1ns/1ps
module mbs_sys_model
(
  input wire ref_clk,
  input wire rst,
  input wire barrier_cmd_valid,
  input wire mark_youngest_probe,
  input wire [3:0] lag,
  output wire barrier_done_response,
  output wire marked_probe_resp_sent
);
  reg [4:0] cmd_wait;
  reg [4:0] mark_wait;
  // answer delay set by bench so both prompt and slow replies occur
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmd_wait <= 5'h00;
      mark_wait <= 5'h00;
    end
    else
    begin
      cmd_wait <= barrier_cmd_valid ? {1'b0, lag} + 5'h02 : cmd_wait - (cmd_wait != 5'h00);
      mark_wait <= mark_youngest_probe ? {1'b0, lag} + 5'h02 : mark_wait - (mark_wait != 5'h00);
    end
  end
  assign barrier_done_response = (cmd_wait == 5'h01);
  assign marked_probe_resp_sent = (mark_wait == 5'h01);
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "mbs_consts.vh"
module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd_q;
  logic txn_issue = 0, probe_cmd_valid = 0, probe_commit_flag = 0, system_data_control_cmd_cmd_valid = 0;
  logic system_data_control_cmd_commit_flag = 0, full_barrier_fetch = 0, issue_queue_empty = 1, maf_pending = 0;
  logic maf_dstream_refs = 0, store_queue_empty = 1, load_queue_empty = 1, write_barrier_ready = 0;
  logic probe_queue_empty = 1, dtlb_move_queued = 0, dtlb_move_issued = 0, itlb_move_queued = 0;
  logic itlb_move_issued = 0, pte_load_done = 0, io_write_buffer_push_valid = 0, io_write_buffer_drain_ready = 0;
  logic [`MBS_ADDR_W-1:0] io_write_buffer_push_addr = '0;
  logic [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] io_write_buffer_push_data = '0;
  logic [3:0] lag = 4'h0;
  wire [31:0] prdata;
  wire [`MBS_ADDR_W-1:0] io_write_buffer_drain_addr;
  wire [`MBS_IO_WRITE_BUFFER_DATA_W-1:0] io_write_buffer_drain_data;
  wire pready, pslverr, barrier_done_response, marked_probe_resp_sent, barrier_cmd_valid;
  wire barrier_ack, map_stall, maf_stall, maf_flush, mark_youngest_probe, writeable_ptr_stall;
  wire merge_close, barrier_complete, scoreboard_bit0, scoreboard_bit4, fetch_stall;
  wire prefetch_restart, io_write_buffer_push_ready, io_write_buffer_drain_valid;
  int fail_count = 0, samples_checked = 0;
  mbs_barrier_seq u_mbs_barrier_seq (.*);
  mbs_sys_model u_mbs_sys_model (.*);
  always #12.5 ref_clk = ~ref_clk;
  // answer captured at the taking edge, before registers move
  always @(posedge ref_clk)
  begin
    rd_q <= prdata;
    err_q <= pslverr;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1 r = rd_q;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: sel = barrier_complete;
      1: sel = mark_youngest_probe;
      2: sel = barrier_cmd_valid;
      default: sel = barrier_ack;
    endcase
  endfunction
  function automatic logic [3:0] sat(input int n);
    sat = n > 15 ? 4'hF : n[3:0];
  endfunction
  task automatic wait_out(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (sel(k) !== 1'b1 && n < 400);
    chk(1, n < 400, "wait_out");
  endtask
  task automatic commit(input logic via_probe);
    @(posedge ref_clk);
    {probe_cmd_valid, probe_commit_flag} <= {2{via_probe}};
    {system_data_control_cmd_cmd_valid, system_data_control_cmd_commit_flag} <= {2{!via_probe}};
    @(posedge ref_clk);
    {probe_cmd_valid, probe_commit_flag, system_data_control_cmd_cmd_valid, system_data_control_cmd_commit_flag} <= 4'h0;
  endtask
  task automatic txns(input int n);
    @(posedge ref_clk);
    txn_issue <= 1'b1;
    repeat (n) @(posedge ref_clk);
    txn_issue <= 1'b0;
  endtask
  initial
  begin
    #500000;
    fail_count++;
    close_out;
  end
  initial
  begin
    logic [31:0] r;
    logic [31:0] wd [0:3];
    int n;
    int k;
    void'($urandom(32'hFE06FC39));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, `MBS_OFF_CTRL, 0, r);
    chk(`MBS_CTRL_RESET, r, "ctrl_reset");
    apb(0, 12'h0FC, 0, r);
    chk(1, err_q, "unmapped_err");
    n = $urandom_range(22, 15);
    txns(n);
    apb(0, `MBS_OFF_STATUS, 0, r);
    chk(sat(n), r[3:0], "count_sat");
    chk(1, maf_stall, "sat_stall");
    commit(1'b1);
    apb(0, `MBS_OFF_STATUS, 0, r);
    chk(14, r[3:0], "probe_commit");
    repeat (15) commit($urandom_range(1, 0) == 1);
    apb(0, `MBS_OFF_STATUS, 0, r);
    chk(0, r[3:0], "count_floor");
    apb(1, `MBS_OFF_CTRL, 32'h3, r);
    txns(2);
    apb(0, `MBS_OFF_STATUS, 0, r);
    chk(0, r[3:0], "count_bus_on");
    for (k = 0; k < 4; k++)
    begin
      apb(1, `MBS_OFF_CTRL, {30'h0, 1'b1, ~k[0]}, r);
      lag <= 4'($urandom_range(9, 0));
      if (k[0])
        txns(2);
      @(posedge ref_clk);
      if (k < 2)
        {issue_queue_empty, load_queue_empty, store_queue_empty, maf_dstream_refs, maf_pending,
          full_barrier_fetch} <= 6'h07;
      else
        write_barrier_ready <= 1'b1;
      @(posedge ref_clk);
      {full_barrier_fetch, write_barrier_ready} <= 2'h0;
      // write barrier command pulses in the cycle after the start cycle
      if (k == 2)
        wait_out(2);
      else
      begin
        @(posedge ref_clk);
        #1;
      end
      chk(k < 2, map_stall, "map_stall");
      chk(k >= 2, writeable_ptr_stall, "wptr_stall");
      chk(k >= 2, maf_stall, "wb_maf_stall");
      @(posedge ref_clk);
      {issue_queue_empty, load_queue_empty, store_queue_empty, maf_dstream_refs, maf_pending}
        <= 5'h1C;
      if (k[0])
        fork
          wait_out(1);
          begin
            commit(1'b0);
            commit(1'b1);
          end
        join
      else if (k == 0)
        wait_out(2);
      if (k == 2)
        wait_out(3);
      wait_out(0);
      chk(0, map_stall | writeable_ptr_stall | maf_stall, "stalls_drop");
    end
    for (k = 0; k < 2; k++)
    begin
      apb(1, `MBS_OFF_CTRL, k ? 32'h1 : 32'h3, r);
      @(posedge ref_clk);
      dtlb_move_queued <= 1'b1;
      @(posedge ref_clk);
      dtlb_move_queued <= 1'b0;
      #1;
      chk(3, {scoreboard_bit4, scoreboard_bit0}, "sb_set");
      @(posedge ref_clk);
      dtlb_move_issued <= 1'b1;
      @(posedge ref_clk);
      dtlb_move_issued <= 1'b0;
      #1;
      chk(!k, {scoreboard_bit4, scoreboard_bit0}, "sb_issue");
      if (!k)
      begin
        wait_out(2);
        wait_out(0);
        @(posedge ref_clk);
        #1;
        chk(0, scoreboard_bit0, "sb0_clear");
      end
    end
    apb(1, `MBS_OFF_CTRL, 32'h3, r);
    @(posedge ref_clk);
    itlb_move_queued <= 1'b1;
    @(posedge ref_clk);
    itlb_move_queued <= 1'b0;
    {pte_load_done, itlb_move_issued, probe_queue_empty} <= 3'h6;
    @(posedge ref_clk);
    {pte_load_done, itlb_move_issued} <= 2'h0;
    wait_out(2);
    chk(1, fetch_stall, "fetch_stall");
    @(posedge ref_clk);
    probe_queue_empty <= 1'b1;
    wait_out(0);
    chk(1, prefetch_restart, "prefetch_restart");
    chk(0, scoreboard_bit0, "itlb_sb0");
    chk(0, fetch_stall, "fetch_free");
    for (k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      wd[k] = $urandom;
      io_write_buffer_push_valid <= 1'b1;
      io_write_buffer_push_data <= {16{wd[k]}};
      io_write_buffer_push_addr <= {8'h00, wd[k]};
    end
    @(posedge ref_clk);
    io_write_buffer_push_valid <= 1'b0;
    #1;
    chk(0, io_write_buffer_push_ready, "io_write_buffer_full");
    apb(0, `MBS_OFF_STATUS, 0, r);
    chk(`MBS_IO_WRITE_BUFFER_ENTRIES, r[10:8], "io_write_buffer_count");
    @(posedge ref_clk);
    io_write_buffer_drain_ready <= 1'b1;
    // newest entry stays open for merging, so only three drain
    for (k = 0; k < 3; k++)
    begin
      #1;
      chk(1, io_write_buffer_drain_valid, "io_write_buffer_drain_valid");
      chk(wd[k], io_write_buffer_drain_data[511:480], "io_write_buffer_drain_data");
      chk(wd[k], io_write_buffer_drain_addr[31:0], "io_write_buffer_drain_addr");
      @(posedge ref_clk);
    end
    #1;
    chk(0, io_write_buffer_drain_valid, "io_write_buffer_merge_open");
    close_out;
  end
endmodule
